// ### tsr_params.svh
// constants of the temperature sensor register map
`ifndef TSR_PARAMS_SVH
`define TSR_PARAMS_SVH
`define TSR_PTR_TEMP 8'h00
`define TSR_PTR_CFG 8'h01
`define TSR_PTR_HYST 8'h02
`define TSR_PTR_CRIT 8'h03
`define TSR_PTR_LOW 8'h04
`define TSR_PTR_HIGH 8'h05
`define TSR_RST_TEMP 16'h0000
`define TSR_RST_CFG 6'h00
`define TSR_RST_HYST 16'h0100
`define TSR_RST_CRIT 16'h2800
`define TSR_RST_LOW 16'h0500
`define TSR_RST_HIGH 16'h2000
`define TSR_CFG_SHDN 0
`define TSR_CFG_INTMODE 1
`define TSR_CFG_OTPOL 2
`define TSR_CFG_ALPOL 3
`define TSR_CFG_FQ 4
`define TSR_CFG_TODIS 5
`define TSR_CFG_W 6
`define TSR_LIM_ZERO 7'h00
`define TSR_LINE_IDLE 1'b1
`define TSR_FRAC_ZERO 4'h0
`define TSR_FQ_SHALLOW 3'h1
`define TSR_FQ_DEEP 3'h4
`define TSR_BITS_PER_BYTE 4'h8
`define TSR_DEV_ADDR 7'h48
`define TSR_CLK_PERIOD_NS 5
`define TSR_TIMEOUT_NS 25000000
`define TSR_TIMEOUT_CYC ((`TSR_TIMEOUT_NS + `TSR_CLK_PERIOD_NS - 1) / `TSR_CLK_PERIOD_NS)
`endif

// ### tsr_pkg.sv
// types of the temperature sensor register map
package tsr_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} tsr_bus_state_t;
   typedef enum logic [1:0] {BK_ADDR, BK_PTR, BK_DATA} tsr_rx_kind_t;
   typedef struct packed {
      logic [8:0] hyst;
      logic [8:0] crit;
      logic [8:0] low;
      logic [8:0] high;
   } tsr_lim_set_t;
   typedef struct packed {
      logic shutdown;
      logic intMode;
      logic deep;
      logic activeHigh;
   } tsr_alarm_cfg_t;
   typedef struct packed {
      logic active;
      logic watchRelax;
      logic [2:0] cnt;
      logic pinOe;
   } tsr_alarm_st_t;
   typedef struct packed {
      logic sclS1;
      logic sclS2;
      logic sclPrev;
      logic sdaS1;
      logic sdaS2;
      logic sdaPrev;
      tsr_bus_state_t state;
      tsr_rx_kind_t kind;
      logic [3:0] bitCnt;
      logic [7:0] shift;
      logic rnw;
      logic ackOk;
      logic byteIdx;
      logic gotMsb;
      logic [7:0] ptr;
      logic [7:0] msbHold;
      logic sdaOe;
      logic hostRead;
      logic [22:0] toCnt;
      logic [15:0] temp;
      logic [5:0] cfg;
      tsr_lim_set_t lim;
   } tsr_main_st_t;
endpackage

// ### tsr_alarm_chan.sv
// one alarm output with fault queue, mode and polarity
`timescale 1ns/1ps
`include "tsr_params.svh"
module tsr_alarm_chan (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic convStb,
   input wire logic faultNow,
   input wire logic relaxNow,
   input wire logic hostRead,
   input wire tsr_pkg::tsr_alarm_cfg_t cfg,
   output logic alarmActive,
   output logic pinOe
);
   tsr_pkg::tsr_alarm_st_t s_r;
   tsr_pkg::tsr_alarm_st_t s_nxt;
   logic [2:0] depth;
   logic target;

   always_comb begin
      s_nxt = s_r;
      depth = cfg.deep ? `TSR_FQ_DEEP : `TSR_FQ_SHALLOW;
      // comparator watches for release once asserted
      target = (cfg.intMode ? s_r.watchRelax : s_r.active) ? relaxNow : faultNow;
      if (cfg.shutdown) begin
         s_nxt.cnt = '0;
      end else begin
         if (cfg.intMode && hostRead) begin
            s_nxt.active = 1'b0;
         end
         if (convStb) begin
            if (cfg.intMode && s_r.active && !hostRead) begin
               // a raised interrupt waits for a read before watching again
               s_nxt.cnt = '0;
            end else if (!target) begin
               s_nxt.cnt = '0;
            end else if (s_r.cnt + 3'h1 >= depth) begin
               s_nxt.cnt = '0;
               if (cfg.intMode) begin
                  s_nxt.active = 1'b1;
                  s_nxt.watchRelax = ~s_r.watchRelax;
               end else begin
                  s_nxt.active = ~s_r.active;
               end
            end else begin
               s_nxt.cnt = s_r.cnt + 3'h1;
            end
         end
      end
      // open drain: pull low unless the pin must float high; held in shutdown
      if (!cfg.shutdown) begin
         s_nxt.pinOe = cfg.activeHigh ? ~s_nxt.active : s_nxt.active;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign alarmActive = s_r.active;
   assign pinOe = s_r.pinOe;
endmodule

// ### tsr_register_map.sv
// pointer addressed register map with serial slave and alarms
//
// Summary of operation
// - eight-bit pointer selects temperature, config, hysteresis, critical, lower, upper
// - temperature register is read-only, resets to zero, writes ignored
// - temperature sign sits in bit 15, magnitude down to bit 3
// - result is two's complement, one step is a sixteenth degree
// - bits 2, 1, 0 flag critical, upper and lower limit alarms
// - configuration resets to zero
// - config bit 0 set puts the sensor into shutdown
// - config bit 1 picks comparator or interrupt alert behaviour
// - config bits 3 and 2 set alert and overtemp polarity
// - config bit 5 set disables the bus timeout
// - config bit 4 picks fault queue depth of one or four
// - limits hold sign at bit 15 and magnitude in bits 14 to 7
// - limit bits 6 to 0 read zero and ignore writes
// - shutdown stops conversions, keeps result, latches alarms, resets queue
// - interrupt alert stays until any read, then watches hysteresis crossing
// - in-tolerance conversion with alarm idle clears the fault queue
`timescale 1ns/1ps
`include "tsr_params.svh"
module tsr_register_map #(
   parameter logic [6:0] DEV_ADDR = `TSR_DEV_ADDR,
   parameter int TIMEOUT_CYC = `TSR_TIMEOUT_CYC
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   input wire logic convValid,
   input wire logic [12:0] convData,
   output logic shutdownReq,
   output logic alertOut,
   output logic alertOe,
   output logic overtempOut,
   output logic overtempOe
);
   ////////////////////////////////////////////////////////////////////////////////
   localparam logic [15:0] RST_HYST = `TSR_RST_HYST;
   localparam logic [15:0] RST_CRIT = `TSR_RST_CRIT;
   localparam logic [15:0] RST_LOW = `TSR_RST_LOW;
   localparam logic [15:0] RST_HIGH = `TSR_RST_HIGH;
   localparam logic [22:0] TO_LAST = 23'(TIMEOUT_CYC);
   // bus pins idle high, so the synchronisers start there and see no false edge
   localparam tsr_pkg::tsr_main_st_t ST_RST = '{
      sclS1: `TSR_LINE_IDLE,
      sclS2: `TSR_LINE_IDLE,
      sclPrev: `TSR_LINE_IDLE,
      sdaS1: `TSR_LINE_IDLE,
      sdaS2: `TSR_LINE_IDLE,
      sdaPrev: `TSR_LINE_IDLE,
      state: tsr_pkg::ST_IDLE,
      kind: tsr_pkg::BK_ADDR,
      bitCnt: '0,
      shift: '0,
      rnw: '0,
      ackOk: '0,
      byteIdx: '0,
      gotMsb: '0,
      ptr: '0,
      msbHold: '0,
      sdaOe: '0,
      hostRead: '0,
      toCnt: '0,
      temp: `TSR_RST_TEMP,
      cfg: `TSR_RST_CFG,
      lim: '{hyst: RST_HYST[15:7],
             crit: RST_CRIT[15:7],
             low: RST_LOW[15:7],
             high: RST_HIGH[15:7]}
   };

   tsr_pkg::tsr_main_st_t s_r;
   tsr_pkg::tsr_main_st_t s_nxt;
   tsr_pkg::tsr_alarm_cfg_t alertCfg;
   tsr_pkg::tsr_alarm_cfg_t otCfg;
   logic sclRise;
   logic sclFall;
   logic startSeen;
   logic stopSeen;
   logic timedOut;
   logic convStb;
   logic signed [13:0] tNow;
   logic overCrit;
   logic overHigh;
   logic underLow;
   logic relaxAlert;
   logic relaxCrit;
   logic alertFault;
   logic [7:0] txByte;

   ////////////////////////////////////////////////////////////////////////////////
   // limit in degrees widened to sixteenths
   function automatic logic signed [13:0] limWide(input logic [8:0] v);
      limWide = {v[8], v, `TSR_FRAC_ZERO};
   endfunction

   // byte of the addressed register, high byte first
   function automatic logic [7:0] regByte(input tsr_pkg::tsr_main_st_t st);
      logic [15:0] w;
      w = '0;
      unique case (st.ptr)
         `TSR_PTR_TEMP: w = st.temp;
         `TSR_PTR_CFG: w = {8'h00, 2'b00, st.cfg};
         `TSR_PTR_HYST: w = {st.lim.hyst, `TSR_LIM_ZERO};
         `TSR_PTR_CRIT: w = {st.lim.crit, `TSR_LIM_ZERO};
         `TSR_PTR_LOW: w = {st.lim.low, `TSR_LIM_ZERO};
         `TSR_PTR_HIGH: w = {st.lim.high, `TSR_LIM_ZERO};
         default: w = '0;
      endcase
      if (st.ptr == `TSR_PTR_CFG) begin
         regByte = w[7:0];
      end else begin
         regByte = st.byteIdx ? w[7:0] : w[15:8];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // temperature compare against limits
   always_comb begin
      tNow = {convData[12], convData};
      overCrit = tNow > limWide(s_r.lim.crit);
      overHigh = tNow > limWide(s_r.lim.high);
      underLow = tNow < limWide(s_r.lim.low);
      relaxAlert = (tNow < limWide(s_r.lim.high) - limWide(s_r.lim.hyst)) &&
                   (tNow > limWide(s_r.lim.low) + limWide(s_r.lim.hyst));
      relaxCrit = tNow < limWide(s_r.lim.crit) - limWide(s_r.lim.hyst);
      // alert trips above the upper or below the lower limit
      alertFault = overHigh || underLow;
      convStb = convValid && !s_r.cfg[`TSR_CFG_SHDN];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // bus line events from the synchronised pins
   always_comb begin
      sclRise = s_r.sclS2 && !s_r.sclPrev;
      sclFall = !s_r.sclS2 && s_r.sclPrev;
      startSeen = s_r.sclS2 && s_r.sclPrev && s_r.sdaPrev && !s_r.sdaS2;
      stopSeen = s_r.sclS2 && s_r.sclPrev && !s_r.sdaPrev && s_r.sdaS2;
      timedOut = (s_r.toCnt == TO_LAST);
      txByte = regByte(s_r);
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_nxt = s_r;
      s_nxt.hostRead = 1'b0;
      s_nxt.sclS1 = sclIn;
      s_nxt.sclS2 = s_r.sclS1;
      s_nxt.sclPrev = s_r.sclS2;
      s_nxt.sdaS1 = sdaIn;
      s_nxt.sdaS2 = s_r.sdaS1;
      s_nxt.sdaPrev = s_r.sdaS2;

      // conversion result with alarm flags
      if (convStb) begin
         s_nxt.temp = {convData, overCrit, overHigh, underLow};
      end

      // clock held low too long inside a transfer
      if (s_r.cfg[`TSR_CFG_TODIS] || s_r.sclS2 ||
          s_r.state == tsr_pkg::ST_IDLE) begin
         s_nxt.toCnt = '0;
      end else if (!timedOut) begin
         s_nxt.toCnt = s_r.toCnt + 23'h1;
      end

      if (startSeen) begin
         s_nxt.state = tsr_pkg::ST_RX;
         s_nxt.kind = tsr_pkg::BK_ADDR;
         s_nxt.bitCnt = '0;
         s_nxt.sdaOe = 1'b0;
      end else if (stopSeen || timedOut) begin
         s_nxt.state = tsr_pkg::ST_IDLE;
         s_nxt.sdaOe = 1'b0;
      end else begin
         unique case (s_r.state)
            tsr_pkg::ST_IDLE: begin
               s_nxt.sdaOe = 1'b0;
            end
            tsr_pkg::ST_RX: begin
               if (sclRise && s_r.bitCnt != `TSR_BITS_PER_BYTE) begin
                  s_nxt.shift = {s_r.shift[6:0], s_r.sdaS2};
                  s_nxt.bitCnt = s_r.bitCnt + 4'h1;
               end else if (sclFall && s_r.bitCnt == `TSR_BITS_PER_BYTE) begin
                  s_nxt.sdaOe = 1'b1;
                  s_nxt.state = tsr_pkg::ST_ACK;
                  unique case (s_r.kind)
                     tsr_pkg::BK_ADDR: begin
                        if (s_r.shift[7:1] == DEV_ADDR) begin
                           s_nxt.rnw = s_r.shift[0];
                           s_nxt.byteIdx = 1'b0;
                           s_nxt.hostRead = s_r.shift[0];
                        end else begin
                           s_nxt.sdaOe = 1'b0;
                           s_nxt.state = tsr_pkg::ST_IDLE;
                        end
                     end
                     tsr_pkg::BK_PTR: begin
                        s_nxt.ptr = s_r.shift;
                        s_nxt.gotMsb = 1'b0;
                     end
                     tsr_pkg::BK_DATA: begin
                        if (s_r.ptr == `TSR_PTR_CFG) begin
                           // reserved bits are not kept
                           s_nxt.cfg = s_r.shift[`TSR_CFG_W-1:0];
                        end else if (s_r.ptr >= `TSR_PTR_HYST &&
                                     s_r.ptr <= `TSR_PTR_HIGH) begin
                           if (!s_r.gotMsb) begin
                              s_nxt.msbHold = s_r.shift;
                              s_nxt.gotMsb = 1'b1;
                           end else begin
                              s_nxt.gotMsb = 1'b0;
                              unique case (s_r.ptr)
                                 `TSR_PTR_HYST: s_nxt.lim.hyst = {s_r.msbHold, s_r.shift[7]};
                                 `TSR_PTR_CRIT: s_nxt.lim.crit = {s_r.msbHold, s_r.shift[7]};
                                 `TSR_PTR_LOW: s_nxt.lim.low = {s_r.msbHold, s_r.shift[7]};
                                 default: s_nxt.lim.high = {s_r.msbHold, s_r.shift[7]};
                              endcase
                           end
                        end
                        // temperature and unmapped pointers drop the write
                     end
                     default: begin
                        s_nxt.state = tsr_pkg::ST_IDLE;
                        s_nxt.sdaOe = 1'b0;
                     end
                  endcase
               end
            end
            tsr_pkg::ST_ACK: begin
               if (sclFall) begin
                  s_nxt.bitCnt = '0;
                  if (s_r.rnw) begin
                     s_nxt.state = tsr_pkg::ST_TX;
                     s_nxt.shift = {txByte[6:0], 1'b0};
                     s_nxt.sdaOe = !txByte[7];
                  end else begin
                     s_nxt.state = tsr_pkg::ST_RX;
                     s_nxt.sdaOe = 1'b0;
                     s_nxt.kind = (s_r.kind == tsr_pkg::BK_ADDR) ?
                                  tsr_pkg::BK_PTR : tsr_pkg::BK_DATA;
                  end
               end
            end
            tsr_pkg::ST_TX: begin
               if (sclRise) begin
                  s_nxt.bitCnt = s_r.bitCnt + 4'h1;
               end else if (sclFall) begin
                  if (s_r.bitCnt == `TSR_BITS_PER_BYTE) begin
                     s_nxt.sdaOe = 1'b0;
                     s_nxt.state = tsr_pkg::ST_MACK;
                     s_nxt.byteIdx = ~s_r.byteIdx;
                  end else begin
                     s_nxt.sdaOe = !s_r.shift[7];
                     s_nxt.shift = {s_r.shift[6:0], 1'b0};
                  end
               end
            end
            tsr_pkg::ST_MACK: begin
               if (sclRise) begin
                  s_nxt.ackOk = !s_r.sdaS2;
               end else if (sclFall) begin
                  s_nxt.bitCnt = '0;
                  if (s_r.ackOk) begin
                     s_nxt.state = tsr_pkg::ST_TX;
                     s_nxt.shift = {txByte[6:0], 1'b0};
                     s_nxt.sdaOe = !txByte[7];
                  end else begin
                     s_nxt.state = tsr_pkg::ST_IDLE;
                  end
               end
            end
            default: begin
               s_nxt.state = tsr_pkg::ST_IDLE;
               s_nxt.sdaOe = 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= ST_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // alarm channels
   always_comb begin
      alertCfg.shutdown = s_r.cfg[`TSR_CFG_SHDN];
      alertCfg.intMode = s_r.cfg[`TSR_CFG_INTMODE];
      alertCfg.deep = s_r.cfg[`TSR_CFG_FQ];
      alertCfg.activeHigh = s_r.cfg[`TSR_CFG_ALPOL];
      otCfg.shutdown = s_r.cfg[`TSR_CFG_SHDN];
      otCfg.intMode = 1'b0;
      otCfg.deep = s_r.cfg[`TSR_CFG_FQ];
      otCfg.activeHigh = s_r.cfg[`TSR_CFG_OTPOL];
   end

   tsr_alarm_chan u_alert (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .convStb(convStb),
      .faultNow(alertFault),
      .relaxNow(relaxAlert),
      .hostRead(s_r.hostRead),
      .cfg(alertCfg),
      .alarmActive(),
      .pinOe(alertOe)
   );

   // overtemp is always a comparator, so reads never clear it
   tsr_alarm_chan u_overtemp (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .convStb(convStb),
      .faultNow(overCrit),
      .relaxNow(relaxCrit),
      .hostRead(1'b0),
      .cfg(otCfg),
      .alarmActive(),
      .pinOe(overtempOe)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // open drain pins only ever pull low
   assign sdaOut = 1'b0;
   assign alertOut = 1'b0;
   assign overtempOut = 1'b0;
   assign sdaOe = s_r.sdaOe;
   assign shutdownReq = s_r.cfg[`TSR_CFG_SHDN];
endmodule

// ### tsr_register_map_asserts.sv
// port checks of the sensor register map
`timescale 1ns/1ps
module tsr_register_map_asserts #(
   parameter logic [6:0] DEV_ADDR = 7'h48,
   parameter int TIMEOUT_CYC = 200
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic sclIn,
   input wire logic sdaIn,
   input wire logic sdaOut,
   input wire logic sdaOe,
   input wire logic convValid,
   input wire logic [12:0] convData,
   input wire logic shutdownReq,
   input wire logic alertOut,
   input wire logic alertOe,
   input wire logic overtempOut,
   input wire logic overtempOe
);
   logic sclPrev_r, sdaPrev_r;
   logic [3:0] fall_r, quiet_r;
   ////////////////////////////////////////////////////////////////////////////
   // cycles since a clock fall, and since any pin or conversion activity
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sclPrev_r <= 1'b1;
         sdaPrev_r <= 1'b1;
         fall_r <= 4'hF;
         quiet_r <= 4'h0;
      end else begin
         sclPrev_r <= sclIn;
         sdaPrev_r <= sdaIn;
         fall_r <= (sclPrev_r && !sclIn) ? 4'h0 : fall_r + {3'h0, fall_r != 4'hF};
         quiet_r <= (convValid || sclIn != sclPrev_r || sdaIn != sdaPrev_r) ? 4'h0
            : quiet_r + {3'h0, quiet_r != 4'hF};
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   chk_open_drain: assert property (!sdaOut && !alertOut && !overtempOut)
      else $error("open drain output driven high");
   chk_reset_bus_idle: assert property ($rose(arst_n) |-> !sdaOe && !shutdownReq)
      else $error("bus or shutdown active after reset");
   chk_reset_alarm_idle: assert property ($rose(arst_n) |-> !alertOe && !overtempOe)
      else $error("alarm pin pulled after reset");
   chk_ack_after_fall: assert property ($rose(sdaOe) |-> !sclIn && fall_r <= 4'h8)
      else $error("data pin pulled outside clock low phase");
   chk_sda_steady_high: assert property (sclIn [*8] |-> $stable(sdaOe))
      else $error("data pin moved while clock high");
   chk_shdn_freeze: assert property (
      shutdownReq [*5] |-> $stable(alertOe) && $stable(overtempOe))
      else $error("alarm pin moved in shutdown");
   chk_alarm_quiet: assert property (
      quiet_r >= 4'h8 |-> $stable(alertOe) && $stable(overtempOe))
      else $error("alarm pin moved without cause");
   chk_shdn_quiet: assert property (quiet_r >= 4'h8 |-> $stable(shutdownReq))
      else $error("shutdown request moved without a write");
endmodule
bind tsr_register_map tsr_register_map_asserts #(
   .DEV_ADDR(DEV_ADDR),
   .TIMEOUT_CYC(TIMEOUT_CYC)
) u_chk (
   .clk_sys(clk_sys), .arst_n(arst_n), .sclIn(sclIn), .sdaIn(sdaIn),
   .sdaOut(sdaOut), .sdaOe(sdaOe), .convValid(convValid), .convData(convData),
   .shutdownReq(shutdownReq), .alertOut(alertOut), .alertOe(alertOe),
   .overtempOut(overtempOut), .overtempOe(overtempOe)
);

// ### tsr_host_model.sv
// serial bus host that reaches the sensor register map
`timescale 1ns/1ps
`include "tsr_params.svh"
module tsr_host_model #(
   parameter logic [6:0] DEV_ADDR = `TSR_DEV_ADDR
) (
   input wire logic clk_sys,
   input wire logic sdaLine,
   output logic sclOut,
   output logic sdaLow
);
   int nackCnt;
   initial begin
      sclOut = 1'b1;
      sdaLow = 1'b0;
      nackCnt = 0;
   end
   // quarter of a 160 ns bit
   task automatic qtr();
      repeat (8) @(posedge clk_sys);
   endtask
   // drives b (1 = release) and returns the level seen mid-high
   task automatic xbit(input logic b, output logic s);
      sdaLow <= !b;
      qtr();
      sclOut <= 1'b1;
      qtr();
      s = sdaLine;
      qtr();
      sclOut <= 1'b0;
      qtr();
   endtask
   task automatic start();
      sdaLow <= 1'b0;
      qtr();
      sclOut <= 1'b1;
      qtr();
      sdaLow <= 1'b1;
      qtr();
      sclOut <= 1'b0;
      qtr();
   endtask
   task automatic stop();
      sdaLow <= 1'b1;
      qtr();
      sclOut <= 1'b1;
      qtr();
      sdaLow <= 1'b0;
      qtr();
   endtask
   task automatic putByte(input logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) xbit(d[i], s);
      xbit(1'b1, s);
      if (s) nackCnt++;
   endtask
   task automatic getByte(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) xbit(1'b1, d[i]);
      xbit(last, s);
   endtask
   task automatic writeReg(input logic [7:0] ptr, input logic [15:0] d, input int nBytes);
      start();
      putByte({DEV_ADDR, 1'b0});
      putByte(ptr);
      if (nBytes == 2) putByte(d[15:8]);
      putByte(d[7:0]);
      stop();
   endtask
   task automatic readReg(input logic [7:0] ptr, input int nBytes, output logic [15:0] d);
      d = 16'h0000;
      start();
      putByte({DEV_ADDR, 1'b0});
      putByte(ptr);
      start();
      putByte({DEV_ADDR, 1'b1});
      if (nBytes == 2) getByte(1'b0, d[15:8]);
      getByte(1'b1, d[7:0]);
      stop();
   endtask
endmodule

// ### tsr_register_map_bench.sv
// self-checking bench of the sensor register map
`timescale 1ns/1ps
`include "tsr_params.svh"
module tsr_register_map_bench;
   logic clk_sys, arst_n, hostScl, hostLow, sdaOut, sdaOe, convValid;
   logic shutdownReq, alertOut, alertOe, overtempOut, overtempOe;
   logic [12:0] convData, cv;
   logic [15:0] rd;
   logic [5:0] cfgVal;
   logic [8:0] lim [2:5];
   logic [15:0] rstTab [0:6];
   int n_mismatch, compares, cycles;
   wire logic sdaLine = !(hostLow || sdaOe);
   tsr_register_map #(.TIMEOUT_CYC(200)) i_tsr_register_map (
      .clk_sys(clk_sys), .arst_n(arst_n), .sclIn(hostScl), .sdaIn(sdaLine),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .convValid(convValid), .convData(convData),
      .shutdownReq(shutdownReq), .alertOut(alertOut), .alertOe(alertOe),
      .overtempOut(overtempOut), .overtempOe(overtempOe));
   tsr_host_model u_host (.clk_sys(clk_sys), .sdaLine(sdaLine), .sclOut(hostScl),
      .sdaLow(hostLow));
   ////////////////////////////////////////////////////////////////////////////
   task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic pin(input string what, input logic exp, input logic got);
      cmp(what, {15'h0000, exp}, {15'h0000, got});
   endtask
   task automatic setLim(input logic [7:0] p, input logic [8:0] v);
      lim[p] = v;
      u_host.writeReg(p, {v, 7'($urandom)}, 2);
   endtask
   task automatic conv(input logic [12:0] d);
      convValid <= 1'b1;
      convData <= d;
      @(posedge clk_sys);
      convValid <= 1'b0;
      repeat (4) @(posedge clk_sys);
   endtask
   task automatic stall(input logic toDis);
      logic s;
      logic [7:0] a;
      a = {`TSR_DEV_ADDR, 1'b0};
      u_host.writeReg(8'h01, {10'h000, toDis, 5'h00}, 1);
      u_host.start();
      for (int i = 7; i >= 0; i--) u_host.xbit(a[i], s);
      // clock held low past the timeout while the device acknowledges
      repeat (250) @(posedge clk_sys);
      pin("data pull", toDis, sdaOe);
      u_host.xbit(1'b1, s);
      u_host.stop();
   endtask
   function automatic logic [15:0] tempWord(input logic [12:0] c);
      int t;
      t = int'($signed(c));
      return {c, t > 16 * int'($signed(lim[3])), t > 16 * int'($signed(lim[5])),
         t < 16 * int'($signed(lim[4]))};
   endfunction
   task automatic final_report();
      if (n_mismatch == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 90000) begin
         n_mismatch++;
         final_report();
      end
   end
   initial begin
      arst_n = 1'b0;
      convValid = 1'b0;
      convData = 13'h0000;
      rstTab = '{`TSR_RST_TEMP, 16'h0000, `TSR_RST_HYST, `TSR_RST_CRIT, `TSR_RST_LOW,
         `TSR_RST_HIGH, 16'h0000};
      void'($urandom(32'hE5D8C959));
      repeat (8) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      pin("alert enable", 1'b0, alertOe);
      for (int p = 0; p < 7; p++) begin
         u_host.readReg(8'(p), (p == 1 || p == 6) ? 1 : 2, rd);
         cmp("reset value", rstTab[p], rd);
      end
      for (int p = 2; p < 6; p++) setLim(8'(p), 9'($urandom));
      for (int p = 2; p < 6; p++) begin
         u_host.readReg(8'(p), 2, rd);
         cmp("limit", {lim[p], 7'h00}, rd);
      end
      u_host.writeReg(8'h00, 16'($urandom), 2);
      u_host.readReg(8'h00, 2, rd);
      cmp("temperature", 16'h0000, rd);
      repeat (2) begin
         cfgVal = 6'($urandom);
         u_host.writeReg(8'h01, {10'h000, cfgVal}, 1);
         u_host.readReg(8'h01, 1, rd);
         cmp("config", {10'h000, cfgVal}, rd);
         pin("shutdown request", cfgVal[0], shutdownReq);
      end
      stall(1'b1);
      stall(1'b0);
      u_host.writeReg(8'h01, 16'h0000, 1);
      for (int i = 0; i < 3; i++) begin
         cv = (i == 0) ? 13'h1FFF : 13'($urandom);
         conv(cv);
         u_host.readReg(8'h00, 2, rd);
         cmp("temperature", tempWord(cv), rd);
      end
      // hyst 2, critical 40, lower -10, upper 30 degrees
      setLim(8'h02, 9'h002);
      setLim(8'h03, 9'h028);
      setLim(8'h04, 9'h1F6);
      setLim(8'h05, 9'h01E);
      conv(13'h0140);
      u_host.writeReg(8'h01, 16'h0010, 1);
      repeat (3) conv(13'h0230);
      pin("alert enable", 1'b0, alertOe);
      conv(13'h0230);
      pin("alert enable", 1'b1, alertOe);
      repeat (4) conv(13'h02D0);
      pin("overtemp enable", 1'b1, overtempOe);
      u_host.writeReg(8'h01, 16'h001C, 1);
      pin("alert enable", 1'b0, alertOe);
      pin("overtemp enable", 1'b0, overtempOe);
      repeat (4) conv(13'h0140);
      pin("alert enable", 1'b1, alertOe);
      pin("overtemp enable", 1'b1, overtempOe);
      u_host.writeReg(8'h01, 16'h0002, 1);
      conv(13'h0230);
      conv(13'h0140);
      pin("alert enable", 1'b1, alertOe);
      u_host.readReg(8'h00, 2, rd);
      pin("alert enable", 1'b0, alertOe);
      conv(13'h0140);
      pin("alert enable", 1'b1, alertOe);
      u_host.readReg(8'h00, 2, rd);
      u_host.writeReg(8'h01, 16'h0003, 1);
      pin("shutdown request", 1'b1, shutdownReq);
      conv(13'h02D0);
      pin("overtemp enable", 1'b0, overtempOe);
      u_host.readReg(8'h00, 2, rd);
      cmp("temperature", tempWord(13'h0140), rd);
      cmp("missed acknowledge", 16'h0000, 16'(u_host.nackCnt));
      final_report();
   end
endmodule
